// ==== ssdc_pkg.sv ====
// Purpose: shared constants for the sensor supervision and dsp clocking block
// Assumes: 40 MHz system clock standing in for the 8 MHz primary oscillator
// Notes: register offsets, field positions, reset values and cycle counts live here
package ssdc_pkg;
  // clock rates and derived oscillator divide
  localparam int SYS_CLK_HZ = 40_000_000;
  localparam int OSC_HZ = 8_000_000;
  localparam int OSC_DIV = SYS_CLK_HZ / OSC_HZ;
  localparam int MOD_HZ = 1_000_000;
  localparam int MOD_HALF_TICKS = OSC_HZ / (2 * MOD_HZ);
  // oscillator monitor
  localparam int PRESCALE_W = 10;
  localparam int PRESCALE_DIV = 1024;
  localparam int COUNT_W = 8;
  localparam int TICK_PERIOD_NS = 128_000;
  localparam int TICK_CYCLES = TICK_PERIOD_NS / (1_000_000_000 / SYS_CLK_HZ);
  localparam logic [COUNT_W-1:0] COUNT_RESET = 8'h00;
  // register offsets
  localparam logic [5:0] ADDR_CTRL = 6'h10;
  localparam logic [5:0] ADDR_CFG = 6'h11;
  localparam logic [5:0] ADDR_DEFL = 6'h12;
  localparam logic [5:0] ADDR_STAT = 6'h14;
  localparam logic [5:0] ADDR_COUNT = 6'h15;
  // field positions
  localparam int BIT_KEY_LOW = 0;
  localparam int BIT_KEY_HIGH = 1;
  localparam int BIT_SELFTEST = 0;
  localparam int BIT_INIT_LOCK = 1;
  localparam int BIT_RESET_FLAG = 0;
  localparam int BIT_INIT_BUSY = 4;
  // soft reset key sequence, {high, low}
  localparam logic [1:0] KEY_STEP0 = 2'h0;
  localparam logic [1:0] KEY_STEP1 = 2'h1;
  localparam logic [1:0] KEY_STEP2 = 2'h2;
  // stored deflection encoding end points and default content
  localparam logic [7:0] DEFL_MIN_CODE = 8'h00;
  localparam logic [7:0] DEFL_MAX_CODE = 8'hff;
  localparam logic [7:0] DEFL_DEFAULT = 8'h80;
  // initialization length after any device reset
  localparam int INIT_CYCLES = 16;
  localparam int SYNC_N = 5;
endpackage

// ==== ssdc_oscmon.sv ====
// Purpose: oscillator monitor, 10-bit prescaler feeding a free-running 8-bit counter
// Assumes: osc_tick is a one-cycle pulse per primary oscillator period
// Notes: core_rst clears both stages synchronously
`timescale 1ns/1ps
`default_nettype none
module ssdc_oscmon
(
  // clock and reset
  input wire logic sys_clk,
  input wire logic resetn,
  input wire logic core_rst,
  // oscillator tick in
  input wire logic osc_tick,
  // counter out
  output logic [ssdc_pkg::COUNT_W-1:0] count,
  output logic prescale_wrap
);
  logic [ssdc_pkg::PRESCALE_W-1:0] prescale;

  // wrap on the last of 1024 oscillator ticks
  assign prescale_wrap = osc_tick && (prescale == ssdc_pkg::PRESCALE_W'(ssdc_pkg::PRESCALE_DIV - 1)); // see RULE_02

  // prescaler counts oscillator ticks
  always_ff @(posedge sys_clk or negedge resetn)
    if (!resetn)
      prescale <= '0;
    else if (core_rst)
      prescale <= '0;
    else if (osc_tick)
      prescale <= prescale + 1'b1; // see RULE_02

  // counter advances once per prescaler wrap, rolls over naturally
  always_ff @(posedge sys_clk or negedge resetn)
    if (!resetn)
      count <= ssdc_pkg::COUNT_RESET;
    else if (core_rst)
      count <= ssdc_pkg::COUNT_RESET;
    else if (prescale_wrap)
      count <= count + 1'b1; // see RULE_01 see RULE_03
endmodule
`default_nettype wire

// ==== ssdc_top.sv ====
// Purpose: supervision, oscillator monitor, self-test control and dsp clock gating
// Assumes: register port is driven by same-clock serial slave logic
// Notes: monitor pins are asynchronous and pass a three-stage synchroniser
// Function
// RULE_01: keep a free-running 8-bit counter, readable only, writes ignored.
// RULE_02: counter advances only on the wrap of a 1024 oscillator prescaler.
// RULE_03: counter steps every 128 us and wraps every 32.768 ms.
// RULE_04: host checks oscillator by comparing successive counter reads to its time base.
// RULE_05: hold reset while supply or internal regulators are out of limits.
// RULE_06: digital regulator failure holds reset and ignores register requests.
// RULE_07: analog regulator failure sets reset flag and keeps answering with fault response.
// RULE_08: either ground loss counts as digital regulator failure and forces reset.
// RULE_09: three ordered key writes to the control register reset the device.
// RULE_10: self test enabled suspends offset cancellation.
// RULE_11: self-test control writes accepted only while the init lock is clear.
// RULE_12: stored deflection encodes minimum as 0x00 and maximum as 0xff.
// RULE_13: modulator delivers its bit stream at a nominal 1 MHz.
// RULE_14: processing clock is 8 MHz, gated to an effective 6 MHz.
// RULE_15: suppress one processing clock just before each modulator clock edge.
// RULE_16: reset flag is set during initialization after any device reset.
// RULE_17: reading the status register clears the reset flag.
// RULE_18: gate is a synchronous enable from the modulator's own oscillator.
`timescale 1ns/1ps
`default_nettype none
module ssdc_top
#(
  parameter int OSC_DIV = ssdc_pkg::OSC_DIV,
  parameter logic [7:0] DEFL_VALUE = ssdc_pkg::DEFL_DEFAULT
)
(
  // clock and reset
  input wire logic sys_clk,
  input wire logic resetn,
  // supply and ground monitors
  input wire logic vext_ok,
  input wire logic vreg_ok,
  input wire logic vrega_ok,
  input wire logic vss_lost,
  input wire logic vssa_lost,
  // register port
  input wire logic reg_rd,
  input wire logic reg_wr,
  input wire logic [5:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  // status and control outputs
  output logic device_reset,
  output logic init_busy,
  output logic fault_response,
  output logic self_test_drive,
  output logic offset_cancel_en,
  // dsp clocking
  output logic mod_clk,
  output logic dsp_clk_en
);
  typedef enum logic [1:0] {ST_RESET, ST_INIT, ST_RUN} ssdc_state_t;

  ssdc_state_t state;
  ssdc_state_t next_state;
  logic [ssdc_pkg::SYNC_N-1:0] pin_raw;
  logic [ssdc_pkg::SYNC_N-1:0] s1;
  logic [ssdc_pkg::SYNC_N-1:0] s2;
  logic [ssdc_pkg::SYNC_N-1:0] s3;
  logic [ssdc_pkg::SYNC_N-1:0] pin_f;
  logic [2:0] div_cnt;
  logic [2:0] phase;
  logic [4:0] init_cnt;
  logic [1:0] key_stage;
  logic soft_req;
  logic reset_flag;
  logic vrega_prev;
  logic [7:0] count;
  logic prescale_wrap;
  logic osc_tick;

  // synchroniser: three flops, filtered level moves when stages two and three agree
  assign pin_raw = {vssa_lost, vss_lost, vrega_ok, vreg_ok, vext_ok};
  genvar gi;
  generate
    for (gi = 0; gi < ssdc_pkg::SYNC_N; gi++)
    begin : g_sync
      always_ff @(posedge sys_clk or negedge resetn)
        if (!resetn)
        begin
          s1[gi] <= 1'b0;
          s2[gi] <= 1'b0;
          s3[gi] <= 1'b0;
          pin_f[gi] <= 1'b0;
        end
        else
        begin
          s1[gi] <= pin_raw[gi];
          s2[gi] <= s1[gi];
          s3[gi] <= s2[gi];
          if (s2[gi] == s3[gi])
            pin_f[gi] <= s3[gi];
        end
    end
  endgenerate

  // supply supervision decode
  wire vext_f = pin_f[0];
  wire vreg_f = pin_f[1];
  wire vrega_f = pin_f[2];
  wire gnd_lost = pin_f[3] | pin_f[4]; // see RULE_08
  wire vreg_fail = !vreg_f || gnd_lost; // see RULE_08
  wire hold = !vext_f || vreg_fail || (!vrega_f && state != ST_RUN); // see RULE_05 see RULE_06
  wire analog_fell = (state == ST_RUN) && vrega_prev && !vrega_f; // see RULE_07
  wire init_last = (init_cnt == 5'(ssdc_pkg::INIT_CYCLES - 1));
  wire core_rst = (state == ST_RESET);

  // register access decode, nothing answers while held in reset
  wire access_ok = !core_rst; // see RULE_06
  wire wr_ctl = reg_wr && access_ok && (reg_addr == ssdc_pkg::ADDR_CTRL);
  wire wr_cfg = reg_wr && access_ok && (reg_addr == ssdc_pkg::ADDR_CFG);
  wire rd_stat = reg_rd && access_ok && (reg_addr == ssdc_pkg::ADDR_STAT);
  wire init_lock;
  wire [1:0] key_in = {reg_wdata[ssdc_pkg::BIT_KEY_HIGH], reg_wdata[ssdc_pkg::BIT_KEY_LOW]};
  wire key_match0 = (key_in == ssdc_pkg::KEY_STEP0);
  wire key_done = wr_ctl && (key_stage == 2'd2) && (key_in == ssdc_pkg::KEY_STEP2); // see RULE_09

  // state sequencing: reset, then initialization, then run
  always_comb
  begin
    next_state = state;
    case (state)
      ST_RESET: if (!hold) next_state = ST_INIT;
      ST_INIT: if (init_last) next_state = ST_RUN;
      ST_RUN: ;
      default: next_state = ST_RESET;
    endcase
    if (hold || soft_req)
      next_state = ST_RESET; // see RULE_05 see RULE_09
  end

  always_ff @(posedge sys_clk or negedge resetn)
    if (!resetn)
      state <= ST_RESET;
    else
      state <= next_state;

  // initialization length counter
  always_ff @(posedge sys_clk or negedge resetn)
    if (!resetn)
      init_cnt <= '0;
    else if (state == ST_INIT)
      init_cnt <= init_cnt + 1'b1;
    else
      init_cnt <= '0;

  // soft reset key sequencer, a wrong key restarts the sequence
  always_ff @(posedge sys_clk or negedge resetn)
    if (!resetn)
    begin
      key_stage <= 2'd0;
      soft_req <= 1'b0;
    end
    else
    begin
      soft_req <= key_done; // see RULE_09
      if (core_rst || key_done)
        key_stage <= 2'd0;
      else if (wr_ctl)
      begin
        if (key_stage == 2'd1 && key_in == ssdc_pkg::KEY_STEP1)
          key_stage <= 2'd2;
        else
          key_stage <= key_match0 ? 2'd1 : 2'd0; // see RULE_09
      end
    end

  // reset flag: set during init and on analog failure, set wins over read clear
  always_ff @(posedge sys_clk or negedge resetn)
    if (!resetn)
      reset_flag <= 1'b0;
    else if ((state == ST_INIT) || analog_fell)
      reset_flag <= 1'b1; // see RULE_16 see RULE_07
    else if (rd_stat)
      reset_flag <= 1'b0; // see RULE_17

  // configuration: self-test control guarded by the init lock
  logic selftest;
  logic lock_q;
  assign init_lock = lock_q;
  always_ff @(posedge sys_clk or negedge resetn)
    if (!resetn)
    begin
      selftest <= 1'b0;
      lock_q <= 1'b0;
    end
    else if (core_rst)
    begin
      selftest <= 1'b0;
      lock_q <= 1'b0;
    end
    else if (wr_cfg && !init_lock)
    begin
      selftest <= reg_wdata[ssdc_pkg::BIT_SELFTEST]; // see RULE_11
      lock_q <= reg_wdata[ssdc_pkg::BIT_INIT_LOCK];
    end

  // registered status outputs
  always_ff @(posedge sys_clk or negedge resetn)
    if (!resetn)
    begin
      vrega_prev <= 1'b0;
      fault_response <= 1'b0;
      self_test_drive <= 1'b0;
      offset_cancel_en <= 1'b0;
      device_reset <= 1'b1;
      init_busy <= 1'b0;
    end
    else
    begin
      vrega_prev <= vrega_f;
      fault_response <= (state == ST_RUN) && !vrega_f; // see RULE_07
      self_test_drive <= selftest;
      offset_cancel_en <= !selftest && (state == ST_RUN); // see RULE_10
      device_reset <= (next_state == ST_RESET);
      init_busy <= (next_state == ST_INIT);
    end

  // oscillator monitor instance
  ssdc_oscmon u_oscmon
  (
    .sys_clk(sys_clk),
    .resetn(resetn),
    .core_rst(core_rst),
    .osc_tick(osc_tick),
    .count(count),
    .prescale_wrap(prescale_wrap)
  );

  // read mux, count register has no write path
  wire [7:0] stat_val = {3'h0, init_busy, 3'h0, reset_flag};
  wire [7:0] cfg_val = {6'h0, lock_q, selftest};
  wire [7:0] rd_mux =
    (reg_addr == ssdc_pkg::ADDR_STAT) ? stat_val :
    (reg_addr == ssdc_pkg::ADDR_COUNT) ? count : // see RULE_01
    (reg_addr == ssdc_pkg::ADDR_CFG) ? cfg_val :
    (reg_addr == ssdc_pkg::ADDR_DEFL) ? DEFL_VALUE : 8'h00; // see RULE_12

  always_ff @(posedge sys_clk or negedge resetn)
    if (!resetn)
      reg_rdata <= 8'h00;
    else if (reg_rd)
      reg_rdata <= access_ok ? rd_mux : 8'h00;

  // oscillator tick: one pulse every OSC_DIV system cycles
  assign osc_tick = (div_cnt == 3'(OSC_DIV - 1)); // see RULE_18
  always_ff @(posedge sys_clk or negedge resetn)
    if (!resetn)
      div_cnt <= 3'd0;
    else
      div_cnt <= osc_tick ? 3'd0 : div_cnt + 1'b1;

  // modulator clock toggles every fourth tick; the tick before each edge is dropped
  wire mod_edge = osc_tick && (phase[1:0] == 2'(ssdc_pkg::MOD_HALF_TICKS - 1)); // see RULE_13
  // the tick that launches the modulator edge would clock the dsp on that edge, so drop it
  wire pre_edge = (phase[1:0] == 2'(ssdc_pkg::MOD_HALF_TICKS - 1));
  always_ff @(posedge sys_clk or negedge resetn)
    if (!resetn)
    begin
      phase <= 3'd0;
      mod_clk <= 1'b0;
    end
    else if (osc_tick)
    begin
      phase <= phase + 1'b1;
      if (mod_edge)
        mod_clk <= !mod_clk; // see RULE_13
    end
  assign dsp_clk_en = osc_tick && !pre_edge && !core_rst; // see RULE_14 see RULE_15 see RULE_18

  // checks
  property p_count_wrap;
    @(posedge sys_clk) disable iff (!resetn)
    (prescale_wrap && !core_rst) |=> (count == $past(count) + 8'h01);
  endproperty
  a_count_wrap: assert property (p_count_wrap) else $error("counter missed prescaler wrap"); // see RULE_02

  property p_count_only_wrap;
    @(posedge sys_clk) disable iff (!resetn)
    (!$past(prescale_wrap) && !$past(core_rst)) |-> $stable(count);
  endproperty
  a_count_only_wrap: assert property (p_count_only_wrap) else $error("counter moved off wrap"); // see RULE_01

  property p_hold;
    @(posedge sys_clk) disable iff (!resetn)
    (!vext_f || vreg_fail) |=> device_reset;
  endproperty
  a_hold: assert property (p_hold) else $error("reset not held on bad supply"); // see RULE_05

  property p_no_answer;
    @(posedge sys_clk) disable iff (!resetn)
    (reg_rd && core_rst) |=> (reg_rdata == 8'h00);
  endproperty
  a_no_answer: assert property (p_no_answer) else $error("read answered in reset"); // see RULE_06

  property p_analog;
    @(posedge sys_clk) disable iff (!resetn)
    (analog_fell && !hold) |=> (reset_flag && fault_response && !device_reset);
  endproperty
  a_analog: assert property (p_analog) else $error("analog failure mishandled"); // see RULE_07

  property p_soft;
    @(posedge sys_clk) disable iff (!resetn)
    key_done |-> ##2 device_reset;
  endproperty
  a_soft: assert property (p_soft) else $error("key sequence did not reset"); // see RULE_09

  property p_st_offset;
    @(posedge sys_clk) disable iff (!resetn)
    self_test_drive |-> !offset_cancel_en;
  endproperty
  a_st_offset: assert property (p_st_offset) else $error("offset cancel during self test"); // see RULE_10

  property p_lock;
    @(posedge sys_clk) disable iff (!resetn)
    (lock_q && wr_cfg && !core_rst) |=> ##1 $stable(self_test_drive);
  endproperty
  a_lock: assert property (p_lock) else $error("self test changed while locked"); // see RULE_11

  property p_init_flag;
    @(posedge sys_clk) disable iff (!resetn)
    (state == ST_INIT) |=> reset_flag;
  endproperty
  a_init_flag: assert property (p_init_flag) else $error("reset flag not set in init"); // see RULE_16

  property p_flag_clear;
    @(posedge sys_clk) disable iff (!resetn)
    (rd_stat && state == ST_RUN && !analog_fell) |=> !reset_flag;
  endproperty
  a_flag_clear: assert property (p_flag_clear) else $error("status read kept flag"); // see RULE_17

  property p_gate;
    @(posedge sys_clk) disable iff (!resetn)
    $changed(mod_clk) |-> (phase[1:0] == 2'd0) && !$past(dsp_clk_en);
  endproperty
  a_gate: assert property (p_gate) else $error("clock not suppressed before edge"); // see RULE_15

  c_soft: cover property (@(posedge sys_clk) disable iff (!resetn) key_done);
  c_analog: cover property (@(posedge sys_clk) disable iff (!resetn) analog_fell);
  c_count_wrap: cover property (@(posedge sys_clk) disable iff (!resetn)
    prescale_wrap && count == 8'hff);
  c_lock_write: cover property (@(posedge sys_clk) disable iff (!resetn) lock_q && wr_cfg);
endmodule
`default_nettype wire

// ==== ssdc_host_model.sv ====
// Purpose: register master model standing in for the host controller
// Assumes: one-cycle read and write strobes on the same clock as the block
// Notes: write data is inverted once released so stale values never look valid
`timescale 1ns/1ps
`default_nettype none
module ssdc_host_model
(
  // clock
  input wire logic sys_clk,
  // register port
  output logic reg_rd,
  output logic reg_wr,
  output logic [5:0] reg_addr,
  output logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata
);
  // idle bus at time zero
  initial
  begin
    reg_rd = 1'b0;
    reg_wr = 1'b0;
    reg_addr = 6'h00;
    reg_wdata = 8'h00;
  end

  // one write strobe, taken at the following edge
  task automatic write_reg(input logic [5:0] addr, input logic [7:0] data);
    @(posedge sys_clk);
    reg_wr <= 1'b1;
    reg_addr <= addr;
    reg_wdata <= data;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
    reg_wdata <= ~data;
  endtask

  // one read strobe, data sampled once the taking edge has landed
  task automatic read_reg(input logic [5:0] addr, output logic [7:0] data);
    @(posedge sys_clk);
    reg_rd <= 1'b1;
    reg_addr <= addr;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1;
    data = reg_rdata;
  endtask

  // three ordered key writes to the control register
  task automatic soft_reset_key;
    write_reg(ssdc_pkg::ADDR_CTRL, {6'h00, ssdc_pkg::KEY_STEP0});
    write_reg(ssdc_pkg::ADDR_CTRL, {6'h00, ssdc_pkg::KEY_STEP1});
    write_reg(ssdc_pkg::ADDR_CTRL, {6'h00, ssdc_pkg::KEY_STEP2});
  endtask
endmodule
`default_nettype wire

// ==== tb_top.sv ====
// Purpose: self-checking bench for supervision, oscillator monitor and clock gating
// Assumes: oscillator divide of 1, so a counter step is 1024 cycles
// Notes: supply monitors are driven directly, registers through the host model
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic sys_clk = 1'b0;
  logic resetn = 1'b0;
  logic vext_ok = 1'b1;
  logic vreg_ok = 1'b1;
  logic vrega_ok = 1'b1;
  logic vss_lost = 1'b0;
  logic vssa_lost = 1'b0;
  wire logic reg_rd;
  wire logic reg_wr;
  wire logic [5:0] reg_addr;
  wire logic [7:0] reg_wdata;
  logic [7:0] reg_rdata;
  logic device_reset;
  logic init_busy;
  logic fault_response;
  logic self_test_drive;
  logic offset_cancel_en;
  logic mod_clk;
  logic dsp_clk_en;
  int mismatches = 0;
  int checks_done = 0;
  int cycles = 0;
  logic [7:0] rd_a;
  logic [7:0] rd_b;

  // clock and hang guard
  always #12.5 sys_clk = ~sys_clk;
  always @(posedge sys_clk)
  begin
    cycles <= cycles + 1;
    if (cycles == 20000)
    begin
      mismatches++;
      end_of_test();
    end
  end

  ssdc_top #(.OSC_DIV(1), .DEFL_VALUE(ssdc_pkg::DEFL_MAX_CODE)) ssdc_top_i (
    .sys_clk(sys_clk), .resetn(resetn), .vext_ok(vext_ok), .vreg_ok(vreg_ok),
    .vrega_ok(vrega_ok), .vss_lost(vss_lost), .vssa_lost(vssa_lost), .reg_rd(reg_rd),
    .reg_wr(reg_wr), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .device_reset(device_reset), .init_busy(init_busy), .fault_response(fault_response),
    .self_test_drive(self_test_drive), .offset_cancel_en(offset_cancel_en),
    .mod_clk(mod_clk), .dsp_clk_en(dsp_clk_en));

  ssdc_host_model ssdc_host_model_i (
    .sys_clk(sys_clk), .reg_rd(reg_rd), .reg_wr(reg_wr), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata));

  // verdict and end of run
  task automatic end_of_test;
    if (mismatches == 0 && checks_done > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  // compare and count
  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      mismatches++;
      $display("BAD at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // wait bounded for the internal reset level, sampled clear of the edge
  task automatic wait_reset(input logic lvl);
    for (int i = 0; i < 40; i++)
    begin
      if (device_reset === lvl)
        break;
      @(posedge sys_clk);
      #1;
    end
    check({7'h00, device_reset}, {7'h00, lvl});
  endtask

  // wait bounded for reset and initialization to finish
  task automatic wait_run;
    for (int i = 0; i < 100; i++)
    begin
      if (device_reset === 1'b0 && init_busy === 1'b0)
        break;
      @(posedge sys_clk);
      #1;
    end
    check({6'h00, device_reset, init_busy}, 8'h00);
  endtask

  // reset flag and busy seen during init, set wins there, a status read in run clears
  task automatic t_init;
    wait_reset(1'b0);
    repeat (2) @(posedge sys_clk);
    ssdc_host_model_i.read_reg(ssdc_pkg::ADDR_STAT, rd_a);
    check(rd_a, 8'h11);
    wait_run();
    ssdc_host_model_i.read_reg(ssdc_pkg::ADDR_STAT, rd_a);
    check(rd_a, 8'h01);
    ssdc_host_model_i.read_reg(ssdc_pkg::ADDR_STAT, rd_a);
    check(rd_a, 8'h00);
  endtask

  // counter read-only, one step per 1024 oscillator ticks
  task automatic t_count;
    ssdc_host_model_i.write_reg(ssdc_pkg::ADDR_COUNT, 8'haa);
    ssdc_host_model_i.read_reg(ssdc_pkg::ADDR_COUNT, rd_a);
    repeat (1022) @(posedge sys_clk);
    ssdc_host_model_i.read_reg(ssdc_pkg::ADDR_COUNT, rd_b);
    check(rd_b - rd_a, 8'h01);
    check({7'h00, rd_a == 8'haa && rd_b == 8'hab}, 8'h00);
  endtask

  // enable pulses 6 of 8, never just before a modulator edge
  task automatic t_gate;
    int ens;
    int toggles;
    int viol;
    logic pm;
    logic pe;
    ens = 0;
    toggles = 0;
    viol = 0;
    @(posedge sys_clk);
    #1;
    pm = mod_clk;
    pe = dsp_clk_en;
    repeat (64)
    begin
      @(posedge sys_clk);
      #1;
      if (pe === 1'b1)
        ens++;
      if (mod_clk !== pm)
      begin
        toggles++;
        if (pe !== 1'b0)
          viol++;
      end
      pm = mod_clk;
      pe = dsp_clk_en;
    end
    check(8'(ens), 8'd48);
    check(8'(toggles), 8'd16);
    check(8'(viol), 8'h00);
  endtask

  // self test toggles offset cancellation, lock freezes the setting
  task automatic t_selftest;
    ssdc_host_model_i.write_reg(ssdc_pkg::ADDR_CFG, 8'h01);
    repeat (2) @(posedge sys_clk);
    #1;
    check({6'h00, self_test_drive, offset_cancel_en}, 8'h02);
    ssdc_host_model_i.write_reg(ssdc_pkg::ADDR_CFG, 8'h00);
    repeat (2) @(posedge sys_clk);
    #1;
    check({6'h00, self_test_drive, offset_cancel_en}, 8'h01);
    ssdc_host_model_i.write_reg(ssdc_pkg::ADDR_CFG, 8'h03);
    ssdc_host_model_i.write_reg(ssdc_pkg::ADDR_CFG, 8'h00);
    repeat (2) @(posedge sys_clk);
    #1;
    check({7'h00, self_test_drive}, 8'h01);
  endtask

  // stored deflection, read-only places and an unmapped address
  task automatic t_regs;
    ssdc_host_model_i.write_reg(ssdc_pkg::ADDR_DEFL, 8'h12);
    ssdc_host_model_i.read_reg(ssdc_pkg::ADDR_DEFL, rd_a);
    check(rd_a, 8'hff);
    ssdc_host_model_i.read_reg(6'h3f, rd_a);
    check(rd_a, 8'h00);
  endtask

  // wrong key order ignored, right order resets and clears config
  task automatic t_softreset;
    ssdc_host_model_i.write_reg(ssdc_pkg::ADDR_CTRL, 8'h00);
    ssdc_host_model_i.write_reg(ssdc_pkg::ADDR_CTRL, 8'h02);
    repeat (4) @(posedge sys_clk);
    #1;
    check({7'h00, device_reset}, 8'h00);
    ssdc_host_model_i.soft_reset_key();
    wait_reset(1'b1);
    wait_run();
    check({7'h00, self_test_drive}, 8'h00);
    ssdc_host_model_i.read_reg(ssdc_pkg::ADDR_STAT, rd_a);
    check(rd_a, 8'h01);
  endtask

  // external supply, digital regulator or either ground fault holds reset and mutes the port
  task automatic t_supply;
    for (int k = 0; k < 4; k++)
    begin
      @(posedge sys_clk);
      vext_ok <= (k != 0);
      vreg_ok <= (k != 1);
      vss_lost <= (k == 2);
      vssa_lost <= (k == 3);
      wait_reset(1'b1);
      ssdc_host_model_i.read_reg(ssdc_pkg::ADDR_STAT, rd_a);
      check(rd_a, 8'h00);
      @(posedge sys_clk);
      vext_ok <= 1'b1;
      vreg_ok <= 1'b1;
      vss_lost <= 1'b0;
      vssa_lost <= 1'b0;
      wait_run();
      ssdc_host_model_i.read_reg(ssdc_pkg::ADDR_STAT, rd_a);
      check(rd_a, 8'h01);
    end
  endtask

  // analog regulator fault while running flags without reset
  task automatic t_analog;
    @(posedge sys_clk);
    vrega_ok <= 1'b0;
    repeat (8) @(posedge sys_clk);
    #1;
    check({6'h00, fault_response, device_reset}, 8'h02);
    ssdc_host_model_i.read_reg(ssdc_pkg::ADDR_STAT, rd_a);
    check(rd_a, 8'h01);
  endtask

  // main sequence
  initial
  begin
    repeat (6) @(posedge sys_clk);
    resetn <= 1'b1;
    t_init();
    t_count();
    t_gate();
    t_selftest();
    t_regs();
    t_softreset();
    t_supply();
    t_analog();
    end_of_test();
  end
endmodule
`default_nettype wire
